//--- design/timer8_pkg.sv
// timer8_pkg: register map, field positions, reset values and mode codes
// for the 8-bit timer/counter with one compare channel.
// assumes a 32-bit APB slave, one aligned word per register.
package timer8_pkg;

    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 8;

    // register byte offsets
    localparam logic [7:0]  OFF_CONTROL = 8'h00;
    localparam logic [7:0]  OFF_COUNT   = 8'h04;
    localparam logic [7:0]  OFF_COMPARE = 8'h08;
    localparam logic [7:0]  OFF_FLAG    = 8'h0c;
    localparam logic [7:0]  OFF_MASK    = 8'h10;
    localparam logic [7:0]  OFF_ASYNC   = 8'h14;

    // timer_control_reg fields
    localparam int          CS_LSB      = 0;
    localparam int          WGM_LSB     = 3;
    localparam int          COM_LSB     = 5;
    localparam int          FOC_BIT     = 7;

    // timer_flag_reg / timer_mask_reg fields
    localparam int          OVF_BIT     = 0;
    localparam int          OCF_BIT     = 1;

    // async_status_reg field
    localparam int          ASEL_BIT    = 0;

    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [7:0]  CNT_BOTTOM  = 8'h00;
    localparam logic [7:0]  CNT_MAX     = 8'hff;
    localparam logic [2:0]  CS_STOPPED  = 3'h0;
    localparam logic [1:0]  COM_NONE    = 2'h0;
    localparam logic [1:0]  COM_TOGGLE  = 2'h1;
    localparam logic [1:0]  COM_CLEAR   = 2'h2;
    localparam logic [1:0]  COM_SET     = 2'h3;

    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_PC_PWM   = 2'b01,
        MODE_CTC      = 2'b10,
        MODE_FAST_PWM = 2'b11
    } wave_mode_type;

endpackage : timer8_pkg

//--- design/compare_output_unit.sv
// compare_output_unit: holds the internal compare output state and applies
// the compare output mode on a match, a forced compare or a PWM turn point.
// assumes one-cycle event strobes from the counter in the same clock domain.
`timescale 1ns/1ns
module compare_output_unit
    import timer8_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_reset_n,
    input  wire logic          i_match_event,
    input  wire logic          i_force,
    input  wire logic          i_wrap_event,
    input  wire logic          i_count_up,
    input  wire wave_mode_type i_mode,
    input  wire logic [1:0]    i_com,
    output logic               o_state
);

    logic oc_r;
    logic oc_nxt;
    logic pwm_mode;
    logic com_inv;

    assign pwm_mode = (i_mode == MODE_PC_PWM) || (i_mode == MODE_FAST_PWM);
    assign com_inv  = (i_com == COM_SET);

    // com is read live, so a new setting acts at the very next event
    always_comb begin
        oc_nxt = oc_r;
        if (!pwm_mode) begin
            if (i_match_event || i_force) begin
                unique case (i_com)
                    COM_NONE:   oc_nxt = oc_r;
                    COM_TOGGLE: oc_nxt = ~oc_r;
                    COM_CLEAR:  oc_nxt = 1'b0;
                    COM_SET:    oc_nxt = 1'b1;
                endcase
            end
        end else if (i_com[1]) begin
            // com toggle is reserved in PWM modes and acts as no action
            if (i_mode == MODE_FAST_PWM) begin
                if (i_match_event) begin
                    oc_nxt = com_inv;
                end else if (i_wrap_event) begin
                    oc_nxt = ~com_inv;
                end
            end else if (i_match_event) begin
                oc_nxt = i_count_up ? com_inv : ~com_inv;
            end
        end
    end

    // no mode-change term here: the state survives mode switches
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            oc_r <= 1'b0;
        end else begin
            oc_r <= oc_nxt;
        end
    end

    assign o_state = oc_r;

endmodule : compare_output_unit

//--- design/timer8_counter_compare_unit.sv
// timer8_counter_compare_unit: 8-bit timer/counter with one compare channel,
// APB register access, overflow and compare flags with interrupt requests.
// assumes all inputs, the oscillator pin included, are synchronous to i_clock.
`timescale 1ns/1ns
module timer8_counter_compare_unit
    import timer8_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_reset_n,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    input  wire logic              i_osc_pin_one,
    input  wire logic              i_port_data,
    input  wire logic              i_compare_irq_ack,
    input  wire logic              i_overflow_irq_ack,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic                   o_osc_pin_two,
    output logic                   o_compare_output,
    output logic                   o_pin_override,
    output logic                   o_compare_irq,
    output logic                   o_overflow_irq
);

    // registers and their next-state values
    logic [2:0]        clock_source_select_r;
    wave_mode_type     waveform_mode_select_r;
    logic [1:0]        compare_output_mode_r;
    logic              async_clock_select_r;
    logic [DATA_W-1:0] counter_value_r;
    logic [DATA_W-1:0] counter_value_nxt;
    logic [DATA_W-1:0] compare_value_r;
    logic [DATA_W-1:0] compare_buffer_r;
    logic              compare_match_flag_r;
    logic              compare_match_flag_nxt;
    logic              overflow_flag_r;
    logic              overflow_flag_nxt;
    logic              compare_match_irq_enable_r;
    logic              overflow_irq_enable_r;
    logic              count_up_r;
    logic              count_up_nxt;
    logic              block_r;
    logic              osc_prev_r;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    logic              osc_two_r;
    logic              pin_r;
    logic              override_r;
    logic              compare_irq_r;
    logic              overflow_irq_r;

    // bus decode
    logic              setup_phase;
    logic              access_done;
    logic              wr_en;
    logic              sel_control;
    logic              sel_count;
    logic              sel_compare;
    logic              sel_flag;
    logic              sel_mask;
    logic              sel_async;
    logic              addr_hit;
    logic              wr_control;
    logic              wr_count;
    logic              wr_compare;
    logic              wr_flag;
    logic              wr_mask;
    logic              wr_async;
    logic [7:0]        wbyte;
    logic [31:0]       rdata_mux;

    // counter status
    logic              timer_tick;
    logic              osc_rise;
    logic              at_bottom;
    logic              at_max;
    logic              match;
    logic              top_hit;
    logic              pwm_mode;
    logic              match_event;
    logic              wrap_event;
    logic              force_pulse;
    logic              ovf_event;
    logic              oc_state;
    wave_mode_type     mode_live;
    logic [1:0]        com_live;

    assign setup_phase = i_psel && !i_penable;
    assign access_done = i_psel && i_penable && pready_r;
    assign wr_en       = access_done && i_pwrite && i_pstrb[0];
    assign wbyte       = i_pwdata[7:0];

    assign sel_control = (i_paddr == OFF_CONTROL);
    assign sel_count   = (i_paddr == OFF_COUNT);
    assign sel_compare = (i_paddr == OFF_COMPARE);
    assign sel_flag    = (i_paddr == OFF_FLAG);
    assign sel_mask    = (i_paddr == OFF_MASK);
    assign sel_async   = (i_paddr == OFF_ASYNC);
    assign addr_hit    = sel_control | sel_count | sel_compare
                       | sel_flag | sel_mask | sel_async;

    assign wr_control  = wr_en && sel_control;
    assign wr_count    = wr_en && sel_count;
    assign wr_compare  = wr_en && sel_compare;
    assign wr_flag     = wr_en && sel_flag;
    assign wr_mask     = wr_en && sel_mask;
    assign wr_async    = wr_en && sel_async;

    assign pwm_mode    = (waveform_mode_select_r == MODE_PC_PWM)
                      || (waveform_mode_select_r == MODE_FAST_PWM);

    // the force strobe is never stored, so it always reads as zero
    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (sel_control) begin
            rdata_mux[COM_LSB +: 2] = compare_output_mode_r;
            rdata_mux[WGM_LSB +: 2] = waveform_mode_select_r;
            rdata_mux[CS_LSB +: 3]  = clock_source_select_r;
        end else if (sel_count) begin
            rdata_mux[7:0] = counter_value_r;
        end else if (sel_compare) begin
            rdata_mux[7:0] = pwm_mode ? compare_buffer_r : compare_value_r;
        end else if (sel_flag) begin
            rdata_mux[OCF_BIT] = compare_match_flag_r;
            rdata_mux[OVF_BIT] = overflow_flag_r;
        end else if (sel_mask) begin
            rdata_mux[OCF_BIT] = compare_match_irq_enable_r;
            rdata_mux[OVF_BIT] = overflow_irq_enable_r;
        end else if (sel_async) begin
            rdata_mux[ASEL_BIT] = async_clock_select_r;
        end
    end

    // read data and response are registered in setup, so one access cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= setup_phase ? rdata_mux : 32'h0000_0000;
            pready_r  <= setup_phase;
            pslverr_r <= setup_phase && !addr_hit;
        end
    end

    // timer clock: oscillator edge when async, else every clock
    assign osc_rise   = i_osc_pin_one && !osc_prev_r;
    assign timer_tick = (clock_source_select_r != CS_STOPPED)
                     && (async_clock_select_r ? osc_rise : 1'b1);

    // 8-bit equality compare against the active compare value
    assign at_bottom  = (counter_value_r == CNT_BOTTOM);
    assign at_max     = (counter_value_r == CNT_MAX);
    assign match      = (counter_value_r == compare_value_r);
    assign top_hit    = (waveform_mode_select_r == MODE_CTC) ? match : at_max;

    // a match seen on this tick is dropped if the counter was just written
    assign match_event = timer_tick && match && !block_r;
    assign wrap_event  = timer_tick && at_max
                      && (waveform_mode_select_r == MODE_FAST_PWM);
    // a control write acts with the mode and output mode it carries
    assign mode_live   = wr_control ? wave_mode_type'(wbyte[WGM_LSB +: 2])
                                    : waveform_mode_select_r;
    assign com_live    = wr_control ? wbyte[COM_LSB +: 2] : compare_output_mode_r;
    assign force_pulse = wr_control && wbyte[FOC_BIT]
                      && ((mode_live == MODE_NORMAL) || (mode_live == MODE_CTC));

    // overflow point per mode
    assign ovf_event = timer_tick
        && ((waveform_mode_select_r == MODE_PC_PWM) ? (at_bottom && !count_up_r)
                                                    : at_max);

    always_comb begin
        counter_value_nxt = counter_value_r;
        count_up_nxt      = count_up_r;
        if (timer_tick) begin
            unique case (waveform_mode_select_r)
                MODE_NORMAL, MODE_FAST_PWM: begin
                    counter_value_nxt = counter_value_r + 8'h01;
                end
                MODE_CTC: begin
                    counter_value_nxt = top_hit ? CNT_BOTTOM
                                                : counter_value_r + 8'h01;
                end
                MODE_PC_PWM: begin
                    if (count_up_r ? at_max : at_bottom) begin
                        count_up_nxt = !count_up_r;
                        counter_value_nxt = count_up_r ? counter_value_r - 8'h01
                                                       : counter_value_r + 8'h01;
                    end else begin
                        counter_value_nxt = count_up_r ? counter_value_r + 8'h01
                                                       : counter_value_r - 8'h01;
                    end
                end
            endcase
        end
        if (wr_count) begin
            counter_value_nxt = wbyte;
        end
    end

    // set wins over a same-cycle clear; a written zero is ignored
    assign compare_match_flag_nxt = match_event
        || (compare_match_flag_r
            && !(wr_flag && wbyte[OCF_BIT])
            && !i_compare_irq_ack);
    assign overflow_flag_nxt = ovf_event
        || (overflow_flag_r
            && !(wr_flag && wbyte[OVF_BIT])
            && !i_overflow_irq_ack);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            counter_value_r      <= RST_BYTE;
            count_up_r           <= 1'b1;
            compare_match_flag_r <= 1'b0;
            overflow_flag_r      <= 1'b0;
            osc_prev_r           <= 1'b0;
        end else begin
            counter_value_r      <= counter_value_nxt;
            count_up_r           <= count_up_nxt;
            compare_match_flag_r <= compare_match_flag_nxt;
            overflow_flag_r      <= overflow_flag_nxt;
            osc_prev_r           <= i_osc_pin_one;
        end
    end

    // blocking holds until a tick passes, even while stopped
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            block_r <= 1'b0;
        end else if (wr_count) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clock_source_select_r  <= CS_STOPPED;
            waveform_mode_select_r <= MODE_NORMAL;
            compare_output_mode_r  <= COM_NONE;
        end else if (wr_control) begin
            clock_source_select_r  <= wbyte[CS_LSB +: 3];
            waveform_mode_select_r <= wave_mode_type'(wbyte[WGM_LSB +: 2]);
            compare_output_mode_r  <= wbyte[COM_LSB +: 2];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            compare_match_irq_enable_r <= 1'b0;
            overflow_irq_enable_r      <= 1'b0;
        end else if (wr_mask) begin
            compare_match_irq_enable_r <= wbyte[OCF_BIT];
            overflow_irq_enable_r      <= wbyte[OVF_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            async_clock_select_r <= 1'b0;
        end else if (wr_async) begin
            async_clock_select_r <= wbyte[ASEL_BIT];
        end
    end

    // buffered in PWM modes, loaded at top; direct otherwise
    // the buffer tracks direct writes so a later switch to PWM starts sane
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            compare_buffer_r <= RST_BYTE;
            compare_value_r  <= RST_BYTE;
        end else begin
            if (wr_compare) begin
                compare_buffer_r <= wbyte;
            end
            if (wr_compare && !pwm_mode) begin
                compare_value_r <= wbyte;
            end else if (pwm_mode && timer_tick && at_max) begin
                compare_value_r <= compare_buffer_r;
            end
        end
    end

    compare_output_unit compare_output_unit_i (
        .i_clock       (i_clock),
        .i_reset_n     (i_reset_n),
        .i_match_event (match_event),
        .i_force       (force_pulse),
        .i_wrap_event  (wrap_event),
        .i_count_up    (count_up_r),
        .i_mode        (mode_live),
        .i_com         (com_live),
        .o_state       (oc_state)
    );

    // pin path and interrupt requests, all registered
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osc_two_r      <= 1'b0;
            pin_r          <= 1'b0;
            override_r     <= 1'b0;
            compare_irq_r  <= 1'b0;
            overflow_irq_r <= 1'b0;
        end else begin
            osc_two_r      <= !i_osc_pin_one;
            override_r     <= (compare_output_mode_r != COM_NONE);
            pin_r          <= (compare_output_mode_r != COM_NONE) ? oc_state
                                                                  : i_port_data;
            compare_irq_r  <= compare_match_flag_nxt && compare_match_irq_enable_r;
            overflow_irq_r <= overflow_flag_nxt && overflow_irq_enable_r;
        end
    end

    assign o_prdata         = prdata_r;
    assign o_pready         = pready_r;
    assign o_pslverr        = pslverr_r;
    assign o_osc_pin_two    = osc_two_r;
    assign o_compare_output = pin_r;
    assign o_pin_override   = override_r;
    assign o_compare_irq    = compare_irq_r;
    assign o_overflow_irq   = overflow_irq_r;

endmodule : timer8_counter_compare_unit

//--- test/timer8_sva.sv
// timer8_sva: port-level checks on the timer's bus answers and pin outputs.
// assumes one clock domain; bound onto the top module below.
`timescale 1ns/1ns
module timer8_sva
    import timer8_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_reset_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic        i_osc_pin_one,
    input wire logic        i_port_data,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_osc_pin_two,
    input wire logic        o_compare_output,
    input wire logic        o_pin_override
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wire logic setup_w = i_psel && !i_penable;
    wire logic map_w   = i_paddr <= OFF_ASYNC && i_paddr[1:0] == 2'h0;

    ready_after_setup_a: assert property (setup_w |=> o_pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    error_on_unmapped_a: assert property (setup_w && !map_w |=> o_pslverr)
        else $error("unmapped access not refused");
    no_error_mapped_a: assert property (setup_w && map_w |=> !o_pslverr)
        else $error("mapped access refused");
    idle_data_zero_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    upper_bits_zero_a: assert property (o_prdata[31:8] == 24'h0)
        else $error("read data wider than a byte");
    force_reads_zero_a: assert property (o_pready && !i_pwrite && i_paddr == OFF_CONTROL
        |-> !o_prdata[FOC_BIT]) else $error("force strobe read back");
    osc_inverted_a: assert property (i_reset_n
        |=> o_osc_pin_two == !$past(i_osc_pin_one))
        else $error("oscillator return not inverted");
    port_passthru_a: assert property ($past(i_reset_n) && !o_pin_override
        && !$past(o_pin_override) && !$past(o_pin_override, 2)
        |-> o_compare_output == $past(i_port_data)) else $error("port value not passed");
endmodule : timer8_sva

bind timer8_counter_compare_unit timer8_sva timer8_sva_i (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_osc_pin_one(i_osc_pin_one), .i_port_data(i_port_data),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_osc_pin_two(o_osc_pin_two), .o_compare_output(o_compare_output),
    .o_pin_override(o_pin_override));

//--- test/test_timer8_counter_compare_unit.sv
// test_timer8_counter_compare_unit: register-level tests of the 8-bit timer.
// assumes the checker is bound in; the bench drives every input itself.
`timescale 1ns/1ns
`define CK(a, b) begin \
    checks++; \
    if ((a) !== (b)) begin \
        num_errors++; \
        $display("BAD %0t got %h exp %h", $time, (a), (b)); \
    end \
end
module test_timer8_counter_compare_unit;
    import timer8_pkg::*;
    logic        i_clock = 1'h0, i_reset_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
    logic        i_pwrite = 1'h0, i_osc_pin_one = 1'h0, i_port_data = 1'h0;
    logic        i_compare_irq_ack = 1'h0, i_overflow_irq_ack = 1'h0, err;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [3:0]  i_pstrb = 4'hf;
    logic        o_pready, o_pslverr, o_osc_pin_two, o_compare_output, o_pin_override;
    logic        o_compare_irq, o_overflow_irq;
    int          num_errors = 0, checks = 0;
    // force sequence: set, clear, toggle, mode change, pwm force, toggle
    logic [7:0]  fctl[6] = '{8'he0, 8'hc0, 8'ha0, 8'h30, 8'hb8, 8'ha0};
    logic        fout[6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0};

    timer8_counter_compare_unit timer8_counter_compare_unit_i (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .i_osc_pin_one(i_osc_pin_one), .i_port_data(i_port_data),
        .i_compare_irq_ack(i_compare_irq_ack), .i_overflow_irq_ack(i_overflow_irq_ack),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_osc_pin_two(o_osc_pin_two), .o_compare_output(o_compare_output),
        .o_pin_override(o_pin_override), .o_compare_irq(o_compare_irq),
        .o_overflow_irq(o_overflow_irq));

    initial begin
        forever #50 i_clock = ~i_clock;
    end

    task automatic end_sim();
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic tk(input int n);
        repeat (n) @(posedge i_clock);
    endtask : tk

    // one apb transfer; an idle edge first so psel is never set and cleared at once
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge i_clock);
        i_psel <= 1'h1;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= {24'h0, d};
        @(posedge i_clock);
        i_penable <= 1'h1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            num_errors++;
            end_sim();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'h1, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'h0, 8'h00);
        `CK(rd, e)
    endtask : rdc

    initial begin
        tk(8);
        i_reset_n <= 1'h1;
        for (int k = 0; k < 6; k++) begin
            rdc(8'(4 * k), 32'h0);
        end
        xfer(8'h18, 1'h0, 8'h00);
        `CK(err, 1'h1)
        wr(OFF_COMPARE, 8'h00);
        wr(OFF_COUNT, 8'hfd);
        wr(OFF_CONTROL, 8'h01);
        tk(6);
        wr(OFF_COUNT, 8'h80);
        wr(OFF_CONTROL, 8'h00);
        rdc(OFF_COUNT, 32'h83);
        tk(4);
        rdc(OFF_COUNT, 32'h83);
        rdc(OFF_FLAG, 32'h03);
        wr(OFF_MASK, 8'h03);
        tk(2);
        `CK({o_compare_irq, o_overflow_irq}, 2'h3)
        i_overflow_irq_ack <= 1'h1;
        tk(1);
        i_overflow_irq_ack <= 1'h0;
        tk(2);
        `CK({o_compare_irq, o_overflow_irq}, 2'h2)
        wr(OFF_FLAG, 8'h00);
        rdc(OFF_FLAG, 32'h02);
        wr(OFF_FLAG, 8'h02);
        tk(2);
        `CK(o_compare_irq, 1'h0)
        // counter loaded equal to compare: first tick must not match
        wr(OFF_COMPARE, 8'h20);
        wr(OFF_COUNT, 8'h20);
        wr(OFF_CONTROL, 8'h01);
        tk(4);
        wr(OFF_CONTROL, 8'h00);
        rdc(OFF_FLAG, 32'h00);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_COMPARE, 8'h05);
        wr(OFF_CONTROL, 8'h11);
        tk(20);
        wr(OFF_CONTROL, 8'h10);
        xfer(OFF_COUNT, 1'h0, 8'h00);
        `CK(rd <= 32'h05, 1'h1)
        rdc(OFF_FLAG, 32'h02);
        wr(OFF_FLAG, 8'h03);
        wr(OFF_ASYNC, 8'h01);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_CONTROL, 8'h01);
        tk(5);
        rdc(OFF_COUNT, 32'h00);
        repeat (3) begin
            i_osc_pin_one <= 1'h1;
            tk(2);
            i_osc_pin_one <= 1'h0;
            tk(2);
        end
        rdc(OFF_COUNT, 32'h03);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_ASYNC, 8'h00);
        foreach (fctl[k]) begin
            wr(OFF_CONTROL, fctl[k]);
            tk(2);
            `CK(o_compare_output, fout[k])
        end
        `CK(o_pin_override, 1'h1)
        rdc(OFF_CONTROL, 32'h20);
        rdc(OFF_FLAG, 32'h00);
        wr(OFF_CONTROL, 8'h00);
        i_port_data <= 1'h1;
        tk(2);
        `CK({o_compare_output, o_pin_override}, 2'h2)
        // pwm writes land in the buffer; the active value 0x35 still matches
        wr(OFF_COMPARE, 8'h35);
        wr(OFF_CONTROL, 8'h18);
        wr(OFF_COMPARE, 8'hf0);
        rdc(OFF_COMPARE, 32'hf0);
        wr(OFF_COUNT, 8'h30);
        wr(OFF_CONTROL, 8'h19);
        tk(4);
        wr(OFF_CONTROL, 8'h18);
        rdc(OFF_FLAG, 32'h02);
        wr(OFF_COUNT, 8'hfd);
        wr(OFF_CONTROL, 8'h09);
        tk(6);
        wr(OFF_CONTROL, 8'h08);
        // nine ticks: up to the maximum, then back down
        rdc(OFF_COUNT, 32'hf8);
        wr(OFF_CONTROL, 8'h00);
        rdc(OFF_COMPARE, 32'hf0);
        end_sim();
    end
endmodule : test_timer8_counter_compare_unit
